// ==== core/interval_counter_map.vh ====
// Register map, field positions, codes and timing constants of the interval counter.
`ifndef INTERVAL_COUNTER_MAP_VH
`define INTERVAL_COUNTER_MAP_VH

// Register indices; the byte address is four times the index.
`define TC_IDX_CTL      10'h042
`define TC_IDX_PLD      10'h043
`define TC_IDX_DAT      10'h044
`define TC_IDX_STAT     10'h045
`define TC_ADDR_CTL     ({`TC_IDX_CTL, 2'h0})
`define TC_ADDR_PLD     ({`TC_IDX_PLD, 2'h0})
`define TC_ADDR_DAT     ({`TC_IDX_DAT, 2'h0})
`define TC_ADDR_STAT    ({`TC_IDX_STAT, 2'h0})

// Control register fields.
`define CTL_SEL_LO      0
`define CTL_SEL_HI      1
`define CTL_EN          2
`define CTL_START       3
`define CTL_TXD         4
`define CTL_P2_TIMER    5
`define CTL_P2_OE       6
`define CTL_P2_GPIO     7

// Status register fields.
`define STAT_RXD        0
`define STAT_CARRY      1
`define STAT_WAIT       2
`define STAT_PIN1       3

// Count clock source codes.
`define SRC_MCLK        2'h0
`define SRC_ACLK        2'h1
`define SRC_PIN         2'h2
`define SRC_MCLK_PIN    2'h3

// Reset values.
`define CTL_RST         8'h00
`define PLD_RST         8'h00
`define CNT_RST         8'h00
`define LINE_IDLE       1'b1

// Timing: system clock rate, crystal rate and loop factor N.
`define SYS_CLK_HZ      27'h17D7840
`define XTAL_HZ_DEF     26'h0008000
`define FLL_N_DEF       7'h1F

// Bus answers.
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ==== core/interval_counter_soft_uart.v ====
`include "interval_counter_map.vh"

module interval_counter_soft_uart #(
    parameter            ADDR_W  = 12,
    parameter [25:0]     XTAL_HZ = `XTAL_HZ_DEF,
    parameter [6:0]      FLL_N   = `FLL_N_DEF
) (
    // Clock and reset.
    input  wire              clock_in,
    input  wire              rst_in,
    // AXI4-Lite write address and data.
    input  wire [ADDR_W-1:0] s_axi_awaddr_in,
    input  wire              s_axi_awvalid_in,
    output reg               s_axi_awready_out,
    input  wire [31:0]       s_axi_wdata_in,
    input  wire [3:0]        s_axi_wstrb_in,
    input  wire              s_axi_wvalid_in,
    output reg               s_axi_wready_out,
    // AXI4-Lite write response.
    output reg  [1:0]        s_axi_bresp_out,
    output reg               s_axi_bvalid_out,
    input  wire              s_axi_bready_in,
    // AXI4-Lite read.
    input  wire [ADDR_W-1:0] s_axi_araddr_in,
    input  wire              s_axi_arvalid_in,
    output reg               s_axi_arready_out,
    output reg  [31:0]       s_axi_rdata_out,
    output reg  [1:0]        s_axi_rresp_out,
    output reg               s_axi_rvalid_out,
    input  wire              s_axi_rready_in,
    // Shared port pins.
    input  wire              timer_input_pin_in,
    output reg               port_pin_two_out,
    output reg               port_pin_two_oe_out
);

    localparam [2:0] SEL_NONE = 3'h0;
    localparam [2:0] SEL_CTL  = 3'h1;
    localparam [2:0] SEL_PLD  = 3'h2;
    localparam [2:0] SEL_DAT  = 3'h3;
    localparam [2:0] SEL_STAT = 3'h4;

    localparam [1:0] ST_FREE = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [1:0] ST_RUN  = 2'h2;

    // The master rate is N+1 times the crystal rate; each is the step of its own fractional divider.
    localparam [25:0] ACLK_INC = XTAL_HZ;
    localparam [25:0] MCLK_INC = XTAL_HZ * ({19'h0, FLL_N} + 26'h1);

    // Address decode shared by the read and write paths.
    function [2:0] reg_sel;
        input [ADDR_W-1:0] addr;
        begin
            if (addr == `TC_ADDR_CTL)
                reg_sel = SEL_CTL;
            else if (addr == `TC_ADDR_PLD)
                reg_sel = SEL_PLD;
            else if (addr == `TC_ADDR_DAT)
                reg_sel = SEL_DAT;
            else if (addr == `TC_ADDR_STAT)
                reg_sel = SEL_STAT;
            else
                reg_sel = SEL_NONE;
        end
    endfunction

    // Fractional rate step; the top bit of the result is the tick.
    function [26:0] nco_step;
        input [25:0] acc;
        input [25:0] inc;
        reg   [26:0] sum;
        reg   [26:0] diff;
        begin
            sum  = {1'b0, acc} + {1'b0, inc};
            // The difference is cut to 26 bits so that the tick bit keeps the top of the result.
            diff = sum - `SYS_CLK_HZ;
            if (sum >= `SYS_CLK_HZ)
                nco_step = {1'b1, diff[25:0]};
            else
                nco_step = {1'b0, sum[25:0]};
        end
    endfunction

    reg  [25:0]       aclk_acc_reg;
    reg               aclk_tick_reg;
    reg  [25:0]       mclk_acc_reg;
    reg               mclk_tick_reg;
    reg               pin_meta_reg;
    reg               pin_sync_reg;
    reg               pin_last_reg;
    reg  [7:0]        ctl_reg;
    reg  [7:0]        pld_reg;
    reg  [7:0]        cnt_reg;
    reg               rx_bit_latch_reg;
    reg               tx_bit_latch_reg;
    reg               carry_flag_reg;
    reg  [1:0]        mode_reg;
    reg               aw_held_reg;
    reg               w_held_reg;
    reg  [ADDR_W-1:0] aw_addr_reg;
    reg  [7:0]        w_data_reg;
    reg               w_lane_reg;
    reg  [7:0]        cnt_next;
    reg               rx_bit_latch_next;
    reg               tx_bit_latch_next;

    wire [26:0] aclk_step = nco_step(aclk_acc_reg, ACLK_INC);
    wire [26:0] mclk_step = nco_step(mclk_acc_reg, MCLK_INC);
    wire        pin_rise  = pin_sync_reg & ~pin_last_reg;
    wire        pin_fall  = ~pin_sync_reg & pin_last_reg;
    wire        wr_go     = aw_held_reg & w_held_reg & ~s_axi_bvalid_out;
    wire [2:0]  wr_sel    = reg_sel(aw_addr_reg);
    wire        wr_ok     = wr_go & w_lane_reg;
    // One write strobe per register, decoded once for every process that needs it.
    wire        wr_ctl    = wr_ok & (wr_sel == SEL_CTL);
    wire        wr_pld    = wr_ok & (wr_sel == SEL_PLD);
    wire        wr_dat    = wr_ok & (wr_sel == SEL_DAT);
    wire        wr_stat   = wr_ok & (wr_sel == SEL_STAT);
    wire [1:0]  src_sel   = ctl_reg[`CTL_SEL_HI:`CTL_SEL_LO];
    wire        counting  = ctl_reg[`CTL_EN] & (mode_reg != ST_WAIT);
    wire        at_top    = &cnt_reg;
    reg         count_tick;
    wire        carry     = counting & count_tick & at_top;

    // Auxiliary and master rate ticks derived from the system clock.
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            aclk_acc_reg  <= 26'h0;
            aclk_tick_reg <= 1'b0;
            mclk_acc_reg  <= 26'h0;
            mclk_tick_reg <= 1'b0;
        end else begin
            aclk_acc_reg  <= aclk_step[25:0];
            aclk_tick_reg <= aclk_step[26];
            mclk_acc_reg  <= mclk_step[25:0];
            mclk_tick_reg <= mclk_step[26];
        end
    end

    // Only the second and third stages feed the edge detectors.
    // Reset to the idle line level, so that no false edge follows reset.
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pin_meta_reg <= `LINE_IDLE;
            pin_sync_reg <= `LINE_IDLE;
            pin_last_reg <= `LINE_IDLE;
        end else begin
            pin_meta_reg <= timer_input_pin_in;
            pin_sync_reg <= pin_meta_reg;
            pin_last_reg <= pin_sync_reg;
        end
    end

    // Count clock selector.
    always @* begin
        case (src_sel)
            `SRC_MCLK:     count_tick = mclk_tick_reg;
            `SRC_ACLK:     count_tick = aclk_tick_reg;
            `SRC_PIN:      count_tick = pin_rise;
            `SRC_MCLK_PIN: count_tick = mclk_tick_reg & pin_sync_reg;
            default:       count_tick = 1'b0;
        endcase
    end

    // Control and preload registers.
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ctl_reg <= `CTL_RST;
            pld_reg <= `PLD_RST;
        end else begin
            if (wr_ctl)
                ctl_reg <= w_data_reg;
            if (wr_pld)
                pld_reg <= w_data_reg;
        end
    end

    // Start detection: arming idles the counter until the line falls.
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            mode_reg <= ST_FREE;
        end else begin
            case (mode_reg)
                ST_FREE: begin
                    if (wr_ctl && w_data_reg[`CTL_START])
                        mode_reg <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (wr_ctl && !w_data_reg[`CTL_START])
                        mode_reg <= ST_FREE;
                    else if (pin_fall)
                        mode_reg <= ST_RUN;
                end
                ST_RUN: begin
                    if (wr_ctl)
                        mode_reg <= w_data_reg[`CTL_START] ? ST_WAIT : ST_FREE;
                end
                default: mode_reg <= ST_FREE;
            endcase
        end
    end

    // Counter, carry-out and the two data latches.
    // A load from software outranks a count edge in the same cycle.
    always @* begin
        cnt_next          = cnt_reg;
        rx_bit_latch_next = rx_bit_latch_reg;
        tx_bit_latch_next = tx_bit_latch_reg;
        if (wr_dat) begin
            cnt_next = pld_reg;
        end else if (mode_reg == ST_WAIT) begin
            if (pin_fall)
                cnt_next = pld_reg;
        end else if (carry) begin
            cnt_next          = pld_reg;
            rx_bit_latch_next = pin_sync_reg;
            tx_bit_latch_next = ctl_reg[`CTL_TXD];
        end else if (counting && count_tick) begin
            cnt_next = cnt_reg + 8'h01;
        end
    end

    // The latches reset to the idle line level, so pin two stays quiet until the first carry.
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_reg          <= `CNT_RST;
            rx_bit_latch_reg <= `LINE_IDLE;
            tx_bit_latch_reg <= `LINE_IDLE;
        end else begin
            cnt_reg          <= cnt_next;
            rx_bit_latch_reg <= rx_bit_latch_next;
            tx_bit_latch_reg <= tx_bit_latch_next;
        end
    end

    // Sticky carry flag; a new carry wins over a clear in the same cycle.
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in)
            carry_flag_reg <= 1'b0;
        else if (carry)
            carry_flag_reg <= 1'b1;
        else if (wr_stat && w_data_reg[`STAT_CARRY])
            carry_flag_reg <= 1'b0;
    end

    // Pin two carries either the transmit latch or a plain port value.
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            port_pin_two_out    <= `LINE_IDLE;
            port_pin_two_oe_out <= 1'b0;
        end else begin
            port_pin_two_out    <= ctl_reg[`CTL_P2_TIMER] ?
                                   tx_bit_latch_reg : ctl_reg[`CTL_P2_GPIO];
            port_pin_two_oe_out <= ctl_reg[`CTL_P2_OE];
        end
    end

    // Write channel: address and data are taken in either order.
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out  <= 1'b0;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= `RESP_OKAY;
            aw_held_reg       <= 1'b0;
            w_held_reg        <= 1'b0;
            aw_addr_reg       <= {ADDR_W{1'b0}};
            w_data_reg        <= 8'h00;
            w_lane_reg        <= 1'b0;
        end else begin
            if (s_axi_awready_out && s_axi_awvalid_in) begin
                s_axi_awready_out <= 1'b0;
                aw_held_reg       <= 1'b1;
                aw_addr_reg       <= s_axi_awaddr_in;
            end else if (!aw_held_reg && !s_axi_bvalid_out) begin
                s_axi_awready_out <= 1'b1;
            end
            if (s_axi_wready_out && s_axi_wvalid_in) begin
                s_axi_wready_out <= 1'b0;
                w_held_reg       <= 1'b1;
                w_data_reg       <= s_axi_wdata_in[7:0];
                w_lane_reg       <= s_axi_wstrb_in[0];
            end else if (!w_held_reg && !s_axi_bvalid_out) begin
                s_axi_wready_out <= 1'b1;
            end
            if (wr_go) begin
                aw_held_reg      <= 1'b0;
                w_held_reg       <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    // Read channel; the answer comes one cycle after the address is taken.
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h00000000;
            s_axi_rresp_out   <= `RESP_OKAY;
        end else if (s_axi_arready_out && s_axi_arvalid_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rresp_out   <= `RESP_OKAY;
            case (reg_sel(s_axi_araddr_in))
                SEL_CTL:  s_axi_rdata_out <= {24'h000000, ctl_reg};
                SEL_PLD:  s_axi_rdata_out <= {24'h000000, pld_reg};
                SEL_DAT:  s_axi_rdata_out <= {24'h000000, cnt_reg};
                SEL_STAT: s_axi_rdata_out <= {28'h0000000, pin_sync_reg,
                                              mode_reg == ST_WAIT,
                                              carry_flag_reg, rx_bit_latch_reg};
                default: begin
                    s_axi_rdata_out <= 32'h00000000;
                    s_axi_rresp_out <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end else if (!s_axi_rvalid_out) begin
            s_axi_arready_out <= 1'b1;
        end
    end

endmodule

// ==== tb/interval_bus_checker_properties.sv ====
// Concurrent checks on the register bus of the interval counter.
module interval_bus_checker #(
    parameter ADDR_W = 12
) (
    // Clock and reset.
    input wire logic              clock_in,
    input wire logic              rst_in,
    // Write channels.
    input wire logic              s_axi_awvalid_in,
    input wire logic              s_axi_awready_out,
    input wire logic              s_axi_wvalid_in,
    input wire logic              s_axi_wready_out,
    input wire logic [1:0]        s_axi_bresp_out,
    input wire logic              s_axi_bvalid_out,
    input wire logic              s_axi_bready_in,
    // Read channels.
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic              s_axi_arvalid_in,
    input wire logic              s_axi_arready_out,
    input wire logic [31:0]       s_axi_rdata_out,
    input wire logic [1:0]        s_axi_rresp_out,
    input wire logic              s_axi_rvalid_out,
    input wire logic              s_axi_rready_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    aw_refused_busy_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
        else $error("write accepted while a response is pending");
    resp_held_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped before it was taken");
    resp_retired_a: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
        else $error("write response repeated");
    read_held_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data changed before it was taken");
    ar_refused_busy_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("read accepted while data is pending");
    write_answer_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
        |-> ##[1:2] s_axi_bvalid_out)
        else $error("write response late");
    read_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read data late");
    byte_lane_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000)
        else $error("read data beyond the byte lane");
    unmapped_read_a: assert property (s_axi_arvalid_in && s_axi_arready_out && (s_axi_araddr_in < 12'h108
        || s_axi_araddr_in > 12'h114 || s_axi_araddr_in[1:0] != 2'h0) |=> s_axi_rresp_out == 2'h2)
        else $error("unmapped read not refused");
endmodule

bind interval_counter_soft_uart interval_bus_checker #(.ADDR_W(ADDR_W)) chk (
    .clock_in(clock_in), .rst_in(rst_in), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
    .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in));

// ==== tb/serial_far_end.sv ====
// Remote serial device that drives pin one and watches pin two.
module serial_far_end (
    // Clock.
    input  wire logic clock_in,
    // Shared pins.
    output logic      line_out,
    input  wire logic pin_two_in,
    input  wire logic pin_two_oe_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic seen_bit = 1'b1;
    // The line idles high, the mark state of an asynchronous link.
    initial line_out = 1'b1;
    // Only a driven pin is sampled; a released pin carries no bit.
    always @(posedge clock_in) begin
        if (pin_two_oe_in) seen_bit <= pin_two_in;
    end
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clock_in) line_out <= 1'b0;
            repeat (4) @(posedge clock_in);
            line_out <= 1'b1;
            repeat (4) @(posedge clock_in);
        end
    endtask
    task automatic level(input logic v);
        @(posedge clock_in) line_out <= v;
    endtask
endmodule

// ==== tb/interval_counter_soft_uart_tb.sv ====
// Self-checking bench for the interval counter, its register bus and its pins.
module interval_counter_soft_uart_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 1'b0, rst_in = 1'b1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hF, strb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pin_one, pin_two, pin_two_oe;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata;
    logic [7:0] rd;
    int fail_count = 0;
    int total_checks = 0;
    interval_counter_soft_uart #(.ADDR_W(12)) DUT (.clock_in(clock_in), .rst_in(rst_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .timer_input_pin_in(pin_one), .port_pin_two_out(pin_two),
        .port_pin_two_oe_out(pin_two_oe));
    serial_far_end far (.clock_in(clock_in), .line_out(pin_one), .pin_two_in(pin_two), .pin_two_oe_in(pin_two_oe));
    always #20 clock_in = ~clock_in;
    task automatic compare(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // Each channel is dropped at the edge that takes it; the loop reads pre-edge values.
    task automatic bus_write(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock_in);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {d, d, d, d};
        wstrb <= strb;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (awvalid || wvalid || !bvalid) begin
            @(posedge clock_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic bus_read(input logic [11:0] a);
        @(posedge clock_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (arvalid || !rvalid) begin
            @(posedge clock_in);
            if (arready) arvalid <= 1'b0;
        end
        rd = rdata[7:0];
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic reset_values();
        bus_read(12'h108);
        compare(rd, 8'h00);
        bus_read(12'h10C);
        compare(rd, 8'h00);
        bus_read(12'h114);
        compare(rd, 8'h09);
        bus_read(12'h200);
        compare({6'h00, rs}, 8'h02);
        bus_write(12'h204, 8'h55);
        compare({6'h00, rs}, 8'h02);
    endtask
    task automatic preload_buffer();
        bus_write(12'h10C, 8'h5A);
        bus_write(12'h110, 8'hC3);
        bus_write(12'h10C, 8'h33);
        strb = 4'hE;
        bus_write(12'h10C, 8'h77);
        strb = 4'hF;
        compare({6'h00, rs}, 8'h00);
        bus_read(12'h110);
        compare(rd, 8'h5A);
        bus_read(12'h10C);
        compare(rd, 8'h33);
    endtask
    task automatic source_select();
        bus_write(12'h10C, 8'h00);
        far.level(1'b0);
        bus_write(12'h108, 8'h07);
        bus_write(12'h110, 8'h00);
        repeat (100) @(posedge clock_in);
        bus_read(12'h110);
        compare(rd, 8'h00);
        far.level(1'b1);
        repeat (100) @(posedge clock_in);
        bus_read(12'h110);
        compare({7'h00, rd != 8'h00}, 8'h01);
        bus_write(12'h108, 8'h05);
        bus_write(12'h110, 8'h00);
        repeat (1600) @(posedge clock_in);
        bus_read(12'h110);
        compare({7'h00, rd >= 8'h01 && rd <= 8'h03}, 8'h01);
        bus_write(12'h108, 8'h04);
        bus_write(12'h110, 8'h00);
        repeat (1600) @(posedge clock_in);
        bus_read(12'h110);
        compare({7'h00, rd >= 8'h40 && rd <= 8'h48}, 8'h01);
        bus_write(12'h108, 8'h00);
        bus_write(12'h110, 8'h00);
        repeat (100) @(posedge clock_in);
        bus_read(12'h110);
        compare(rd, 8'h00);
    endtask
    task automatic pin_counting();
        bus_write(12'h108, 8'h66);
        bus_write(12'h10C, 8'hFD);
        bus_write(12'h110, 8'h00);
        far.pulses(2);
        repeat (6) @(posedge clock_in);
        bus_read(12'h110);
        compare(rd, 8'hFF);
        compare({7'h00, pin_two}, 8'h01);
        far.pulses(1);
        repeat (6) @(posedge clock_in);
        bus_read(12'h110);
        compare(rd, 8'hFD);
        bus_read(12'h114);
        compare(rd, 8'h0B);
        compare({6'h00, pin_two_oe, pin_two}, 8'h02);
        compare({7'h00, far.seen_bit}, 8'h00);
        bus_write(12'h114, 8'h02);
        bus_read(12'h114);
        compare(rd, 8'h09);
    endtask
    task automatic start_detect();
        bus_write(12'h10C, 8'hFC);
        bus_write(12'h108, 8'h0C);
        repeat (100) @(posedge clock_in);
        bus_read(12'h110);
        compare(rd, 8'hFD);
        bus_read(12'h114);
        compare(rd & 8'h05, 8'h05);
        far.level(1'b0);
        repeat (20) @(posedge clock_in);
        bus_read(12'h114);
        compare(rd & 8'h05, 8'h01);
        repeat (200) @(posedge clock_in);
        bus_read(12'h114);
        compare(rd & 8'h05, 8'h00);
        far.level(1'b1);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        reset_values();
        preload_buffer();
        source_select();
        pin_counting();
        start_detect();
        results();
    end
    // The sequence needs some 4000 cycles; the limit leaves ample margin.
    initial begin
        #(40 * 20000);
        fail_count++;
        results();
    end
endmodule
